//--- core/output_uv_fault_retry_ctrl.sv
/*
 * Output undervoltage fault response: holds the fault action register,
 * raises the sticky fault bit and, under response codes 10 and 11, the alert line, disables the output and
 * retries after a programmable delay.
 * Assumes the register port, fault clear and on/off inputs come from logic
 * on clk_in; the enable pin, power-good and comparator inputs are asynchronous.
 */
//
// How it works
// [RL1] The action register resets to 80h: shut down immediately, never retry.
// [RL2] Response codes 10 and 11 mean disable and retry per the retry field; 00 and 01 also disable and latch off, but leave the alert line high.
// [RL3] An undervoltage fault under a disable-and-retry code pulls the alert line low.
// [RL4] A fault sets a sticky fault bit that only the fault clear command clears.
// [RL5] Retry setting 000 keeps the output off after a fault until the fault is cleared.
// [RL6] Retry setting 111 restarts again and again until switched off, bias is lost, or another fault.
// [RL7] Restart attempts start (delay field plus one) times 35 ms apart.
// [RL8] Fault detection is masked during ramp, before power-good, and while the output is off.
// [RL9] A prescaler makes the 35 ms tick and restarts at each new attempt.
`timescale 1ns/1ps
module output_uv_fault_retry_ctrl
	import uv_fault_pkg::*;
#(
	parameter int STEP_CYCLES = RETRY_STEP_CYCLES
) (
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	output logic [7:0]      reg_rdata_out,
	input  wire logic       clear_faults_in,
	input  wire logic       enable_pin_in,
	input  wire logic       on_cmd_in,
	input  wire logic       bias_ok_in,
	input  wire logic       other_fault_in,
	input  wire logic       output_in_regulation_in,
	input  wire logic       uv_detect_in,
	output logic            host_alert_line_n_out,
	output logic            uv_fault_bit_out,
	output logic            output_enable_out,
	output logic            retry_start_out
);
	////////////////////////////////////////////////////////////////////////
	logic [7:0] action_r;
	logic [1:0] en_s_r;
	logic [1:0] pg_s_r;
	logic [1:0] uv_s_r;
	logic [1:0] bias_s_r;
	uv_state_t  state_r;
	logic       retry_done;
	logic       commanded_on;
	logic       fault_seen;
	logic       retry_mode;
	logic       go_retry;

	function automatic logic resp_is_retry(input logic [7:0] a);
		return a[RESP_HI];
	endfunction : resp_is_retry

	// Pin inputs pass two flip-flops; only the second stage is read.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			en_s_r   <= '0;
			pg_s_r   <= '0;
			uv_s_r   <= '0;
			bias_s_r <= '0;
		end else begin
			en_s_r   <= {en_s_r[0], enable_pin_in};
			pg_s_r   <= {pg_s_r[0], output_in_regulation_in};
			uv_s_r   <= {uv_s_r[0], uv_detect_in};
			bias_s_r <= {bias_s_r[0], bias_ok_in};
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			action_r <= ACTION_RESET; // see [RL1]
		end else if (reg_wr_in && reg_addr_in == ACTION_OFFSET) begin
			action_r <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reg_rdata_out <= '0;
		end else if (reg_rd_in) begin
			reg_rdata_out <= (reg_addr_in == ACTION_OFFSET) ? action_r : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign commanded_on = en_s_r[1] && on_cmd_in && bias_s_r[1] && !other_fault_in;
	// Masked while off and until power-good after the ramp.
	assign fault_seen   = uv_s_r[1] && output_enable_out && pg_s_r[1]; // see [RL8]
	assign retry_mode   = resp_is_retry(action_r); // see [RL2]
	assign go_retry     = retry_mode && action_r[RETRY_HI:RETRY_LO] == RETRY_FOREVER;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r           <= ST_RUN;
			output_enable_out <= 1'b0;
			retry_start_out   <= 1'b0;
		end else begin
			retry_start_out <= 1'b0;
			case (state_r)
				ST_RUN: begin
					output_enable_out <= commanded_on;
					if (fault_seen) begin
						output_enable_out <= 1'b0;
						state_r <= go_retry ? ST_WAIT : ST_OFF; // see [RL5]
						retry_start_out <= go_retry;
					end
				end
				ST_OFF: begin
					output_enable_out <= 1'b0;
					if (clear_faults_in) begin // see [RL5]
						state_r <= ST_RUN;
					end
				end
				ST_WAIT: begin
					output_enable_out <= 1'b0;
					if (!commanded_on) begin // see [RL6]
						state_r <= ST_RUN;
					end else if (retry_done) begin // see [RL6]
						state_r           <= ST_RUN;
						output_enable_out <= 1'b1;
					end
				end
				default: begin
					state_r           <= ST_RUN;
					output_enable_out <= 1'b0;
				end
			endcase
		end
	end

	retry_timer #(
		.STEP_CYCLES(STEP_CYCLES)
	) u_timer (
		.clk_in   (clk_in),
		.arst_n_in(arst_n_in),
		.start_in (retry_start_out),
		.run_in   (state_r == ST_WAIT),
		.delay_in (action_r[DELAY_HI:DELAY_LO]),
		.done_out (retry_done)
	);

	////////////////////////////////////////////////////////////////////////
	// A fault in the clearing cycle wins over the clear.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			uv_fault_bit_out      <= 1'b0;
			host_alert_line_n_out <= 1'b1;
		end else begin
			if (state_r == ST_RUN && fault_seen) begin
				uv_fault_bit_out <= 1'b1; // see [RL4]
				if (retry_mode) begin
					host_alert_line_n_out <= 1'b0; // see [RL3]
				end
			end else if (clear_faults_in) begin
				uv_fault_bit_out      <= 1'b0; // see [RL4]
				host_alert_line_n_out <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	fault_disables_a: assert property (state_r == ST_RUN && fault_seen |=> !output_enable_out) // see [RL5]
		else $error("Output stayed on after a fault.");
	alert_on_fault_a: assert property (state_r == ST_RUN && fault_seen && retry_mode |=> !host_alert_line_n_out) // see [RL3]
		else $error("Alert not pulled low on fault.");
	bit_sticky_a: assert property (uv_fault_bit_out && !clear_faults_in |=> uv_fault_bit_out) // see [RL4]
		else $error("Fault bit dropped without clear.");
	bit_sets_a: assert property (state_r == ST_RUN && fault_seen |=> uv_fault_bit_out) // see [RL4]
		else $error("Fault bit not set.");
	no_retry_off_a: assert property (state_r == ST_OFF && !clear_faults_in |=> state_r == ST_OFF && !output_enable_out) // see [RL5]
		else $error("No-retry mode left off state.");
	retry_waits_a: assert property (state_r == ST_WAIT |-> !output_enable_out) // see [RL7]
		else $error("Output on during retry delay.");
	stop_off_cmd_a: assert property (state_r == ST_WAIT && !commanded_on |=> state_r == ST_RUN && !output_enable_out) // see [RL6]
		else $error("Retry continued after off command.");
	mask_off_a: assert property (!output_enable_out |=> !$rose(uv_fault_bit_out) || $past(pg_s_r[1])) // see [RL8]
		else $error("Fault taken while masked.");
	reset_value_a: assert property ($rose(arst_n_in) |-> action_r == ACTION_RESET) // see [RL1]
		else $error("Action register reset value wrong.");
endmodule : output_uv_fault_retry_ctrl

//--- core/uv_fault_pkg.sv
/*
 * Constants for the output undervoltage fault response block: register
 * offset, field layout, reset value and retry timing.
 * Assumes a 250 MHz system clock.
 */
package uv_fault_pkg;
	localparam logic [7:0]  ACTION_OFFSET     = 8'h45;
	localparam logic [7:0]  ACTION_RESET      = 8'h80;
	localparam int          RESP_HI           = 7;
	localparam int          RESP_LO           = 6;
	localparam int          RETRY_HI          = 5;
	localparam int          RETRY_LO          = 3;
	localparam int          DELAY_HI          = 2;
	localparam int          DELAY_LO          = 0;
	localparam logic [2:0]  RETRY_NONE        = 3'h0;
	localparam logic [2:0]  RETRY_FOREVER     = 3'h7;
	localparam int          CLK_MHZ           = 250;
	localparam int          RETRY_STEP_MS     = 35;
	localparam int          RETRY_STEP_CYCLES = RETRY_STEP_MS * 1000 * CLK_MHZ;
	localparam int          ALERT_SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_WAIT  = 2'b01,
		ST_OFF   = 2'b10
	} uv_state_t;
endpackage : uv_fault_pkg

//--- core/retry_timer.sv
/*
 * Retry delay timer: a prescaler makes a tick every step period and a step
 * counter ends the delay after (delay + 1) ticks.
 * Assumes a start pulse from the fault controller on the same clock.
 */
`timescale 1ns/1ps
module retry_timer
	import uv_fault_pkg::*;
#(
	parameter int STEP_CYCLES = RETRY_STEP_CYCLES
) (
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	input  wire logic       start_in,
	input  wire logic       run_in,
	input  wire logic [2:0] delay_in,
	output logic            done_out
);
	logic [31:0] presc_r;
	logic [3:0]  steps_r;
	logic        tick;

	assign tick = (presc_r == 32'(STEP_CYCLES - 1));

	// A new attempt restarts both counters so each interval is whole.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			presc_r <= '0;
		end else if (start_in || !run_in || tick) begin // see [RL9]
			presc_r <= '0;
		end else begin
			presc_r <= presc_r + 32'h1;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			steps_r  <= '0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in || !run_in) begin
				steps_r <= '0;
			end else if (tick) begin
				if (steps_r == {1'b0, delay_in}) begin // see [RL7]
					steps_r  <= '0;
					done_out <= 1'b1;
				end else begin
					steps_r <= steps_r + 4'h1;
				end
			end
		end
	end
endmodule : retry_timer

//--- sim/host_model.sv
/*
 * Host side of the register port: byte writes and reads.
 * Assumes the block answers a read one cycle after the read edge.
 */
`timescale 1ns/1ps
module host_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	output logic            wr_out,
	output logic            rd_out,
	output logic [7:0]      addr_out,
	output logic [7:0]      wdata_out
);
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h00;
	end
	// Released lines show the inverse of the last value.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		wr_out = 1'b1;
		addr_out = a;
		wdata_out = d;
		@(posedge clk_in);
		#1;
		wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_in);
		#1;
		rd_out = 1'b1;
		addr_out = a;
		@(posedge clk_in);
		#1;
		rd_out = 1'b0;
		addr_out = ~a;
		v = rdata_in;
	endtask : rd
endmodule : host_model

//--- sim/output_uv_fault_retry_ctrl_bench.sv
/*
 * Self-checking bench for the undervoltage fault response block.
 * Assumes a short retry step so that the delays stay brief.
 */
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module output_uv_fault_retry_ctrl_bench;
	import uv_fault_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
	localparam int S = 4;
	row_t rows[4] = '{'{8'h45, 8'hB8, 8'hB8}, '{8'h45, 8'h5A, 8'h5A}, '{8'h44, 8'h12, 8'h00}, '{8'h46, 8'hFF, 8'h00}};
	logic [7:0] rc[2] = '{8'hB8, 8'hFF};
	logic clk_in = 1'b0, arst_n_in = 1'b0, clr = 1'b0, on = 1'b1, pg = 1'b1, uv = 1'b0;
	logic en = 1'b1, bias = 1'b1, ofl = 1'b0;
	logic wr, rd, alert, fbit, oe, rs;
	logic [7:0] addr, wd, rdat, v;
	int n_errors = 0, checks = 0, cyc = 0, n, exp_n;
	always #2 clk_in = ~clk_in;
	host_model host (.clk_in(clk_in), .rdata_in(rdat), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wd));
	output_uv_fault_retry_ctrl #(.STEP_CYCLES(S)) DUT (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdat), .clear_faults_in(clr),
		.enable_pin_in(en), .on_cmd_in(on), .bias_ok_in(bias), .other_fault_in(ofl),
		.output_in_regulation_in(pg), .uv_detect_in(uv), .host_alert_line_n_out(alert),
		.uv_fault_bit_out(fbit), .output_enable_out(oe), .retry_start_out(rs));
	task automatic tick(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask : tick
	task automatic trip();
		n = 0;
		tick(1);
		uv = 1'b1;
		while (oe !== 1'b0 && n < 10) begin
			tick(1);
			n++;
		end
		uv = 1'b0;
	endtask : trip
	task automatic wait_on();
		n = 0;
		while (oe !== 1'b1 && n < 400) begin
			tick(1);
			n++;
		end
	endtask : wait_on
	task automatic clear();
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		tick(4);
	endtask : clear
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		tick(12);
		arst_n_in = 1'b1;
		tick(4);
		host.rd(ACTION_OFFSET, v);
		`CHK("reset value", ACTION_RESET, v)
		foreach (rows[i]) begin
			host.wr(rows[i].a, rows[i].d);
			host.rd(rows[i].a, v);
			`CHK("readback", rows[i].e, v)
		end
		$display("register test done");
		host.wr(ACTION_OFFSET, ACTION_RESET);
		wait_on();
		trip();
		`CHK("off", 1'b0, oe)
		`CHK("no retry", 1'b0, rs)
		`CHK("alert low", 1'b0, alert)
		tick(40);
		`CHK("stays off", 1'b0, oe)
		`CHK("bit held", 1'b1, fbit)
		clear();
		wait_on();
		`CHK("bit cleared", 1'b0, fbit)
		`CHK("alert off", 1'b1, alert)
		`CHK("restart", 1'b1, oe)
		$display("no retry test done");
		foreach (rc[i]) begin
			host.wr(ACTION_OFFSET, rc[i]);
			trip();
			`CHK("retry start", 1'b1, rs)
			`CHK("fault bit", 1'b1, fbit)
			`CHK("alert", 1'b0, alert)
			wait_on();
			exp_n = (int'(rc[i][2:0]) + 1) * S;
			`CHK("retry gap", 1'b1, n >= exp_n - 2 && n <= exp_n + 4)
			`CHK("bit kept", 1'b1, fbit)
			clear();
		end
		$display("retry test done");
		trip();
		on = 1'b0;
		tick(40);
		`CHK("commanded off", 1'b0, oe)
		on = 1'b1;
		wait_on();
		clear();
		for (int k = 0; k < 3; k++) begin
			trip();
			en = (k != 0);
			bias = (k != 1);
			ofl = (k == 2);
			tick(40);
			`CHK("stopped", 1'b0, oe)
			en = 1'b1;
			bias = 1'b1;
			ofl = 1'b0;
			wait_on();
			`CHK("back on", 1'b1, oe)
			clear();
		end
		pg = 1'b0;
		uv = 1'b1;
		tick(6);
		`CHK("masked", 1'b0, fbit)
		uv = 1'b0;
		pg = 1'b1;
		arst_n_in = 1'b0;
		tick(1);
		`CHK("reset oe", 1'b0, oe)
		arst_n_in = 1'b1;
		tick(4);
		host.rd(ACTION_OFFSET, v);
		`CHK("reset again", ACTION_RESET, v)
		$display("mask and reset test done");
		test_done();
	end
endmodule : output_uv_fault_retry_ctrl_bench
